// ==== dcfifo_pkg.sv ====
/*
 * constants for the flagged fifo: widths, depth, threshold defaults, reset values.
 * assumes nothing of its surroundings; every user writes dcfifo_pkg::name.
 */
package dcfifo_pkg;
	// -----------------------------------------------------------------
	// widths and depth
	// -----------------------------------------------------------------
	localparam int unsigned DATA_W  = 18;
	localparam int unsigned THR_W   = 12;
	localparam int unsigned DEPTH   = 256;
	localparam int unsigned PTR_W   = 8;
	localparam int unsigned CNT_W   = 9;
	localparam int unsigned CMP_W   = 13;
	// -----------------------------------------------------------------
	// reset and default values
	// -----------------------------------------------------------------
	localparam logic [THR_W-1:0]  THR_EMPTY_DEF = 12'h01f;
	localparam logic [THR_W-1:0]  THR_FULL_DEF  = 12'h01f;
	localparam logic [DATA_W-1:0] DOUT_RST      = 18'h0_0000;
	localparam logic [CNT_W-1:0]  CNT_RST       = 9'h000;
	localparam logic [CMP_W-1:0]  DEPTH_CMP     = 13'h0100;
	localparam logic [CNT_W-1:0]  DEPTH_CNT     = 9'h100;
	localparam logic [CNT_W-1:0]  HALF_CNT      = 9'h080;
	localparam logic [PTR_W-1:0]  LAST_LOC      = 8'hff;
	localparam logic [PTR_W-1:0]  FIRST_LOC     = 8'h00;
	// threshold selection: 0 selects empty threshold, 1 the full one
	localparam logic              SEL_EMPTY     = 1'b0;
endpackage

// ==== dcfifo_top.sv ====
/*
 * storage fifo and the flagged fifo top with threshold registers.
 * assumes write and read sides share clk; all inputs are synchronous to clk,
 * the data pins are resolved outside from read_data_out and read_data_oe.
 */
//
// Behaviour
// - reset returns write and read pointers to first location
// - reset sets full, half, almost-full high; empty, almost-empty low
// - reset zeroes output register and loads default thresholds
// - write enable low, load high, not full stores word sequentially
// - full flag low when full, writes ignored, released after read
// - full flag falls after exactly depth writes without reads
// - read enable low, load high, not empty loads output register
// - read enable high holds output register unchanged
// - empty flag low after last read, reads ignored, released after write
// - output enable low drives data pins, high releases them
// - load and write enable low write thresholds empty, full, cyclically
// - threshold write selection persists across load strobe release
// - load low with write enable high does nothing on write side
// - load and read enable low read thresholds with separate pointer
// - almost-full falls after depth minus m writes without reads
// - default full threshold gives almost-full 31 words from full
// - almost-full asserted by writes, released by reads
// - almost-empty low while occupancy is n or fewer
// - almost-empty asserted by reads, released by writes
// - half-full low above half occupancy, high at half or less
`timescale 1ns/1ns
`default_nettype none

module dcfifo_store #(
	parameter int unsigned WIDTH = 18,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [AW:0]      level,
	output logic      [AW-1:0]    wr_loc,
	output logic      [AW-1:0]    rd_loc
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff, nxt_wr_ptr;
	logic [AW-1:0]    rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0]      cnt_ff, nxt_cnt;
	logic             push, pop;

	// honest full and empty straight from the occupancy count
	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_ff];
	assign level     = cnt_ff;
	assign wr_loc    = wr_ptr_ff;
	assign rd_loc    = rd_ptr_ff;

	// pointers wrap naturally because depth is a power of two
	always_comb begin
		nxt_wr_ptr = wr_ptr_ff + AW'(push);
		nxt_rd_ptr = rd_ptr_ff + AW'(pop);
		nxt_cnt    = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff    <= nxt_cnt;
		end
	end

	// array has no reset, so it maps onto block memory
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end
endmodule

module dcfifo_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        write_enable_n,
	input  wire logic        read_enable_n,
	input  wire logic        threshold_load_n,
	input  wire logic        output_enable_n,
	input  wire logic        first_device_select_n,
	input  wire logic        write_chain_in_n,
	input  wire logic        read_chain_in_n,
	input  wire logic [17:0] write_data_in,
	output logic      [17:0] read_data_out,
	output logic             read_data_oe,
	output logic             full_flag_n,
	output logic             empty_flag_n,
	output logic             almost_full_flag_n,
	output logic             almost_empty_flag_n,
	output logic             half_full_flag_n,
	output logic             write_chain_out_n,
	output logic             read_chain_out_n
);
	// -----------------------------------------------------------------
	// storage
	// -----------------------------------------------------------------
	logic                                 wr_req, rd_req, st_ready, st_valid;
	logic [dcfifo_pkg::DATA_W-1:0]        st_data;
	logic [dcfifo_pkg::CNT_W-1:0]         level;
	logic [dcfifo_pkg::PTR_W-1:0]         wr_loc, rd_loc;

	// full and empty gate the requests through ready and valid
	assign wr_req = !write_enable_n && threshold_load_n;
	assign rd_req = !read_enable_n && threshold_load_n;

	dcfifo_store #(
		.WIDTH (dcfifo_pkg::DATA_W),
		.DEPTH (dcfifo_pkg::DEPTH),
		.AW    (dcfifo_pkg::PTR_W)
	) u_store (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (wr_req),
		.in_ready  (st_ready),
		.in_data   (write_data_in),
		.out_valid (st_valid),
		.out_ready (rd_req),
		.out_data  (st_data),
		.level     (level),
		.wr_loc    (wr_loc),
		.rd_loc    (rd_loc)
	);

	logic push, pop;
	assign push = wr_req && st_ready;
	assign pop  = rd_req && st_valid;

	// -----------------------------------------------------------------
	// threshold registers and selections
	// -----------------------------------------------------------------
	logic [dcfifo_pkg::THR_W-1:0] thr_empty_ff, nxt_thr_empty;
	logic [dcfifo_pkg::THR_W-1:0] thr_full_ff, nxt_thr_full;
	logic                         wsel_ff, nxt_wsel, rsel_ff, nxt_rsel;
	logic                         thr_wr, thr_rd;

	// write enable high under load freezes the write side entirely
	assign thr_wr = !threshold_load_n && !write_enable_n;
	assign thr_rd = !threshold_load_n && !read_enable_n;

	always_comb begin
		nxt_thr_empty = thr_empty_ff;
		nxt_thr_full  = thr_full_ff;
		nxt_wsel      = wsel_ff;
		nxt_rsel      = rsel_ff;
		if (thr_wr) begin
			if (wsel_ff == dcfifo_pkg::SEL_EMPTY) begin
				nxt_thr_empty = write_data_in[dcfifo_pkg::THR_W-1:0];
			end else begin
				nxt_thr_full = write_data_in[dcfifo_pkg::THR_W-1:0];
			end
			nxt_wsel = !wsel_ff; // selection kept when load rises
		end
		if (thr_rd) begin
			nxt_rsel = !rsel_ff; // own pointer, independent of writes
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			thr_empty_ff <= dcfifo_pkg::THR_EMPTY_DEF;
			thr_full_ff  <= dcfifo_pkg::THR_FULL_DEF;
			wsel_ff      <= dcfifo_pkg::SEL_EMPTY;
			rsel_ff      <= dcfifo_pkg::SEL_EMPTY;
		end else begin
			thr_empty_ff <= nxt_thr_empty;
			thr_full_ff  <= nxt_thr_full;
			wsel_ff      <= nxt_wsel;
			rsel_ff      <= nxt_rsel;
		end
	end

	// -----------------------------------------------------------------
	// output register and output enable
	// -----------------------------------------------------------------
	logic [dcfifo_pkg::DATA_W-1:0] dout_ff, nxt_dout;
	logic                          oe_ff, nxt_oe;

	always_comb begin
		nxt_dout = dout_ff; // read enable high holds the word
		if (pop) begin
			nxt_dout = st_data;
		end else if (thr_rd) begin
			nxt_dout = {6'h00, (rsel_ff == dcfifo_pkg::SEL_EMPTY) ? thr_empty_ff : thr_full_ff};
		end
		nxt_oe = !output_enable_n;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dout_ff <= dcfifo_pkg::DOUT_RST;
			oe_ff   <= 1'b0;
		end else begin
			dout_ff <= nxt_dout;
			oe_ff   <= nxt_oe;
		end
	end

	assign read_data_out = dout_ff;
	assign read_data_oe  = oe_ff;

	// -----------------------------------------------------------------
	// status flags, all active low, built from the next occupancy and the
	// next thresholds so a threshold write cannot leave a flag one cycle stale
	// -----------------------------------------------------------------
	function automatic logic [dcfifo_pkg::CMP_W-1:0] widen(input logic [dcfifo_pkg::CNT_W-1:0] c);
		widen = {4'h0, c};
	endfunction

	logic [dcfifo_pkg::CNT_W-1:0] nxt_level;
	logic ff_ff, ef_ff, paf_ff, pae_ff, hf_ff, wxo_ff, rxo_ff;
	logic nxt_ff, nxt_ef, nxt_paf, nxt_pae, nxt_hf, nxt_wxo, nxt_rxo;
	logic single_mode;

	// a threshold above the depth keeps almost-full asserted at every occupancy
	assign single_mode = !write_chain_in_n && !read_chain_in_n;

	always_comb begin
		nxt_level = level + {8'h00, push} - {8'h00, pop};
		nxt_ff    = (nxt_level != dcfifo_pkg::DEPTH_CNT);
		nxt_ef    = (nxt_level != dcfifo_pkg::CNT_RST);
		nxt_paf   = (widen(nxt_level) + 13'(nxt_thr_full) < dcfifo_pkg::DEPTH_CMP);
		nxt_pae   = (widen(nxt_level) > 13'(nxt_thr_empty));
		nxt_hf    = (nxt_level <= dcfifo_pkg::HALF_CNT);
		// chained mode: one-cycle low pulse on touching the last location
		nxt_wxo   = single_mode ? nxt_hf : !(push && wr_loc == dcfifo_pkg::LAST_LOC);
		nxt_rxo   = single_mode ? 1'b1 : !(pop && rd_loc == dcfifo_pkg::LAST_LOC);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ff_ff  <= 1'b1;
			paf_ff <= 1'b1;
			hf_ff  <= 1'b1;
			ef_ff  <= 1'b0;
			pae_ff <= 1'b0;
			wxo_ff <= 1'b1;
			rxo_ff <= 1'b1;
		end else begin
			ff_ff  <= nxt_ff;
			paf_ff <= nxt_paf;
			hf_ff  <= nxt_hf;
			ef_ff  <= nxt_ef;
			pae_ff <= nxt_pae;
			wxo_ff <= nxt_wxo;
			rxo_ff <= nxt_rxo;
		end
	end

	assign full_flag_n         = ff_ff;
	assign empty_flag_n        = ef_ff;
	assign almost_full_flag_n  = paf_ff;
	assign almost_empty_flag_n = pae_ff;
	assign half_full_flag_n    = hf_ff;
	assign write_chain_out_n   = wxo_ff;
	assign read_chain_out_n    = rxo_ff;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	logic unused_fl;
	assign unused_fl = first_device_select_n;

	AST_RST_FLAGS: assert property (@(posedge clk) reset |=> full_flag_n && almost_full_flag_n && !empty_flag_n && !almost_empty_flag_n && half_full_flag_n)
		else $error("flags wrong after reset");
	AST_RST_DOUT: assert property (@(posedge clk) reset |=> read_data_out == 18'h0_0000)
		else $error("output register not cleared by reset");
	AST_HOLD: assert property (@(posedge clk) disable iff (reset) read_enable_n |=> $stable(read_data_out))
		else $error("output register changed without read");
	AST_NO_WR_FULL: assert property (@(posedge clk) disable iff (reset) !full_flag_n && read_enable_n |=> !full_flag_n)
		else $error("full flag released without read");
	AST_EMPTY_READ: assert property (@(posedge clk) disable iff (reset) !empty_flag_n && write_enable_n && threshold_load_n |=> !empty_flag_n && $stable(read_data_out))
		else $error("read taken while empty");
	AST_FULL_LEVEL: assert property (@(posedge clk) disable iff (reset) !full_flag_n == (level == 9'h100))
		else $error("full flag disagrees with depth");
	AST_PAF: assert property (@(posedge clk) disable iff (reset) almost_full_flag_n == (widen(level) + 13'(thr_full_ff) < 13'h0100))
		else $error("almost-full flag wrong");
	AST_PAE: assert property (@(posedge clk) disable iff (reset) !almost_empty_flag_n == (widen(level) <= 13'(thr_empty_ff)))
		else $error("almost-empty flag wrong");
	AST_HF: assert property (@(posedge clk) disable iff (reset) half_full_flag_n == (level <= 9'h080))
		else $error("half-full flag wrong");
	AST_THR_WSEL: assert property (@(posedge clk) disable iff (reset) !threshold_load_n && write_enable_n |=> $stable(wsel_ff) && $stable(thr_full_ff))
		else $error("threshold write side moved while disabled");
	AST_OE: assert property (@(posedge clk) disable iff (reset) read_data_oe == (!$past(output_enable_n) && !$past(reset)))
		else $error("output enable not followed");

	COV_FILL: cover property (@(posedge clk) disable iff (reset) !full_flag_n);
	COV_DRAIN: cover property (@(posedge clk) disable iff (reset) !empty_flag_n ##1 empty_flag_n ##[1:20] !empty_flag_n);
	COV_THR_RD: cover property (@(posedge clk) disable iff (reset) thr_rd ##1 thr_rd);
	COV_PAF: cover property (@(posedge clk) disable iff (reset) !almost_full_flag_n && full_flag_n);
endmodule

`default_nettype wire

// ==== dcfifo_pin_model.sv ====
/*
 * consumer-side pin model: resolves the three-state data pins.
 * assumes read_data_oe high means the fifo drives the pins.
 */
`timescale 1ns/1ns
`default_nettype none

module dcfifo_pin_model (
	input  wire logic [17:0] read_data_out,
	input  wire logic        read_data_oe,
	output wire logic [17:0] data_pins
);
	// ----------------------------------------
	// pin resolution
	// ----------------------------------------
	// released pins float, no pull on this bus
	assign data_pins = read_data_oe ? read_data_out : 18'hz;
endmodule

`default_nettype wire

// ==== tb.sv ====
/*
 * self-checking bench for dcfifo_top: reset, data path, flags, thresholds, pins.
 * assumes one shared clock; single-device mode except for one chained run.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic        clk = 1'b0, reset = 1'b1;
	logic        write_enable_n = 1'b1, read_enable_n = 1'b1;
	logic        threshold_load_n = 1'b1, output_enable_n = 1'b0;
	logic [17:0] write_data_in = 18'h0_0000;
	logic [17:0] read_data_out, data_pins;
	logic        read_data_oe, full_flag_n, empty_flag_n;
	logic        almost_full_flag_n, almost_empty_flag_n, half_full_flag_n;
	logic        write_chain_out_n, read_chain_out_n, chain_in_n = 1'b0;
	int          errors = 0, n_tests = 0, thr_n, thr_m;

	// ----------------------------------------
	// clock, design, pins
	// ----------------------------------------
	always #4 clk = ~clk;

	// chain inputs grounded for single-device mode, raised for one chained run
	dcfifo_top dcfifo_top_i (.clk(clk), .reset(reset), .write_enable_n(write_enable_n),
		.read_enable_n(read_enable_n), .threshold_load_n(threshold_load_n),
		.output_enable_n(output_enable_n), .first_device_select_n(1'b0),
		.write_chain_in_n(chain_in_n), .read_chain_in_n(chain_in_n),
		.write_data_in(write_data_in), .read_data_out(read_data_out),
		.read_data_oe(read_data_oe), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
		.almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
		.half_full_flag_n(half_full_flag_n), .write_chain_out_n(write_chain_out_n),
		.read_chain_out_n(read_chain_out_n));

	dcfifo_pin_model dcfifo_pin_model_i (.read_data_out(read_data_out),
		.read_data_oe(read_data_oe), .data_pins(data_pins));

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic conclude();
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	function automatic logic [17:0] wd(input int i);
		return {2'b10, i[7:0], ~i[7:0]};
	endfunction

	// five flags and both chain outputs for an occupancy of c words;
	// wl and rl mark a write or read of the last location in chained mode
	task automatic flags(input int c, input logic wl, input logic rl);
		logic [6:0] e;
		e = {c != 256, c < 256 - thr_m, c <= 128, c > thr_n, c != 0,
			(chain_in_n ? !wl : (c <= 128)), (chain_in_n ? !rl : 1'b1)};
		chk({11'h000, full_flag_n, almost_full_flag_n, half_full_flag_n, almost_empty_flag_n,
			empty_flag_n, write_chain_out_n, read_chain_out_n}, {11'h000, e});
	endtask

	// one request, launched here and taken at the following edge
	task automatic drive(input logic w, input logic r, input logic l, input logic [17:0] d);
		@(posedge clk);
		write_enable_n   <= w;
		read_enable_n    <= r;
		threshold_load_n <= l;
		write_data_in    <= d;
	endtask

	// reset held three cycles, then defaults checked
	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		chain_in_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		thr_n = dcfifo_pkg::THR_EMPTY_DEF;
		thr_m = dcfifo_pkg::THR_FULL_DEF;
		#1 flags(0, 1'b0, 1'b0);
		chk(read_data_out, 18'h0_0000);
	endtask

	task automatic fill(input int cnt);
		for (int i = 0; i <= cnt; i++) begin
			drive(i == cnt, 1'b1, 1'b1, wd(i));
			#1 flags(i, i == 256, 1'b0);
		end
	endtask

	// every word is requested by a read, the first one too
	task automatic drain(input int cnt);
		for (int i = 0; i <= cnt; i++) begin
			drive(1'b1, i == cnt, 1'b1, 18'h0_0000);
			#1 flags(cnt - i, 1'b0, i == 256);
			if (i > 0) chk(read_data_out, wd(i - 1));
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		do_reset();
		drive(1'b1, 1'b0, 1'b0, 18'h0_0000);
		drive(1'b1, 1'b0, 1'b0, 18'h0_0000);
		#1 chk(read_data_out, {6'h00, dcfifo_pkg::THR_EMPTY_DEF});
		drive(1'b1, 1'b1, 1'b1, 18'h0_0000);
		#1 chk(read_data_out, {6'h00, dcfifo_pkg::THR_FULL_DEF});
	endtask

	task automatic t_single();
		fill(1);
		drain(1);
		drive(1'b1, 1'b0, 1'b1, 18'h0_0000);
		repeat (2) drive(1'b1, 1'b1, 1'b1, 18'h0_0000);
		#1 chk(read_data_out, wd(0));
		flags(0, 1'b0, 1'b0);
	endtask

	// full boundary in chained mode from fresh pointers: refused write,
	// last-location pulses on both chain outputs, then complete drain in order
	task automatic t_full();
		do_reset();
		@(posedge clk);
		chain_in_n <= 1'b1;
		fill(256);
		drive(1'b0, 1'b1, 1'b1, 18'h3_ffff);
		drain(256);
	endtask

	task automatic t_thresh();
		do_reset();
		drive(1'b0, 1'b1, 1'b0, 18'h0_0005);
		drive(1'b1, 1'b1, 1'b0, 18'h0_0777);
		drive(1'b1, 1'b1, 1'b1, 18'h0_0000);
		drive(1'b0, 1'b1, 1'b0, 18'h0_00f0);
		drive(1'b1, 1'b0, 1'b0, 18'h0_0000);
		drive(1'b1, 1'b0, 1'b0, 18'h0_0000);
		#1 chk(read_data_out, 18'h0_0005);
		drive(1'b1, 1'b0, 1'b0, 18'h0_0000);
		#1 chk(read_data_out, 18'h0_00f0);
		drive(1'b1, 1'b1, 1'b1, 18'h0_0000);
		#1 chk(read_data_out, 18'h0_0005);
		thr_n = 5;
		thr_m = 240;
		fill(20);
		do_reset();
	endtask

	task automatic t_pins();
		@(posedge clk);
		output_enable_n <= 1'b1;
		@(posedge clk);
		#1 chk(data_pins, 18'hz);
		@(posedge clk);
		output_enable_n <= 1'b0;
		@(posedge clk);
		#1 chk(data_pins, 18'h0_0000);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		t_defaults();
		t_single();
		t_full();
		t_thresh();
		t_pins();
		conclude();
	end

	// about 575 cycles expected; generous margin
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end
endmodule

`default_nettype wire
